// ---- shared/pdr_pkg.sv ----
// Purpose: constants and types for the power-down and reset controller
// Assumes: 100 MHz core clock, one clock domain
// Notes: counts derived from times in their own units
//
// Operation
// - Sub modes: main osc follows mode bit 2
// - Stop halts peripheral clock except watch, display; stop 2 halts those too
// - Stop ties main oscillator input to ground
// - Stop exits on reset, ext, watch, counter
// - Disabled interrupts never wake from stop
// - Event-counter timer interrupt can wake stop
// - Reset clears control state, keeps RAM
// - External wake keeps RAM and control registers
// - Every stop exit waits oscillator start-up
// - Internal reset merges four reset sources
// - Pin reset needs eight low oscillator periods; the filter asserts after nine low samples
// - Release waits 65.5ms plus seven periods
// - Reset sets vector, clears page, G, mode
// - Power-on reset holds until supply good
// - Both options make reset pin a port
package pdr_pkg;

    // ==========================================================
    // Timing
    localparam int CLK_MHZ = 100;
    localparam int OSC_PERIOD_NS = 10;
    localparam int PIN_LOW_PERIODS = 8;
    localparam int RST_WAIT_US = 65500;
    localparam int RST_EXTRA_PERIODS = 7;
    localparam int RST_WAIT_CYC = RST_WAIT_US * CLK_MHZ + RST_EXTRA_PERIODS;
    // Start-up count after a wake from stop; plain default
    localparam int STOP_WAIT_CYC = 2000;
    localparam int CNT_W = 24;

    // ==========================================================
    // Field positions and reset values
    localparam int MODE_REG_MAIN_OFF_BIT = 2;
    localparam logic [15:0] RESET_VECTOR_ADDR = 16'hFFFE;
    localparam logic [7:0] RAM_PAGE_RST = 8'h00;
    localparam logic [1:0] PLL_SEL_PLL = 2'h3;

    // ==========================================================
    // Operating modes
    typedef enum logic [2:0] {
        MODE_MAIN, MODE_SLEEP, MODE_SUB, MODE_SUBSLEEP, MODE_STOP, MODE_STOP2
    } pdr_mode_e;

    // Sequencer phases
    typedef enum logic [1:0] {
        PH_RESET, PH_RUN, PH_STOPPED, PH_WAKEWAIT
    } pdr_phase_e;

endpackage : pdr_pkg

// ---- rtl/pdr_pin_filter.sv ----
// Purpose: qualifies the external reset pin low time
// Assumes: pin sampled synchronously
// Notes: a glitch shorter than the limit is dropped
`timescale 1ns/1ps
module pdr_pin_filter (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Pin
    input wire logic pinLowN,
    input wire logic pinIsReset,
    // Result
    output logic pinReset
);
    typedef struct packed {
        logic [3:0] cnt;
        logic hit;
    } pdr_flt_s;
    pdr_flt_s st_r, st_nxt;

    // ==========================================================
    // Low counter
    always_comb begin
        st_nxt = st_r;
        if (!pinIsReset || pinLowN) begin
            st_nxt.cnt = 4'h0;
            st_nxt.hit = 1'b0;
        end else if (st_r.cnt < 4'(pdr_pkg::PIN_LOW_PERIODS)) begin
            st_nxt.cnt = st_r.cnt + 4'h1;
        end else begin
            st_nxt.hit = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r <= '0;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    assign pinReset = st_r.hit;
endmodule : pdr_pin_filter

// ---- rtl/pdr_wake_gate.sv ----
// Purpose: selects interrupts allowed to end stop
// Assumes: enable bits already latched by software
// Notes: combinational
`timescale 1ns/1ps
module pdr_wake_gate (
    // Requests
    input wire logic extIrq,
    input wire logic watchIrq,
    input wire logic timerIrq,
    input wire logic eventCounterInputPin,
    // Enables
    input wire logic extEn,
    input wire logic watchEn,
    input wire logic timerEn,
    // Result
    output logic wake,
    output logic extWake
);
    // Only enabled sources count; timer only when event-clocked
    assign extWake = extIrq & extEn;
    assign wake = extWake | (watchIrq & watchEn) | (timerIrq & timerEn & eventCounterInputPin);
endmodule : pdr_wake_gate

// ---- rtl/power_down_and_reset_control.sv ----
// Purpose: mode clock gating, stop entry/exit, reset merge
// Assumes: inputs synchronous to clk; software keeps its own rules
// Notes: RAM lives outside and is never reset here
// Notes: software duties (no-ops after stop, long start-up wait,
//        PLL off before stop) are not checked by this block
// Notes: the reset wait is a plain down-counter; shorten it for
//        simulation through the parameter, not the package
`timescale 1ns/1ps
// ==========================================================
// Phases
// Reset: core held while the start-up wait counts down
// Run: mode requests honoured, clocks follow the mode
// Stopped: clocks off bar the sub clock, which stop 2 stops as well, waiting for a wake
// Wake wait: start-up count after a wake, core still frozen
module power_down_and_reset_control #(
    // Cycles from last reset source low to first fetch
    parameter int RstWaitCyc = pdr_pkg::RST_WAIT_CYC,
    // Cycles of start-up after a wake from stop
    parameter int StopWaitCyc = pdr_pkg::STOP_WAIT_CYC
) (
    // Clock and reset
    // ce low freezes every flop, counters included
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Reset sources
    // Pin active low, the other three active high
    input wire logic resetPinN,
    input wire logic porReset,
    input wire logic brownoutReset,
    input wire logic watchdogReset,
    input wire logic porOption,
    input wire logic resetPinAsPortOption,
    // Mode requests
    // One-cycle pulses, honoured in the run phase only
    input wire logic sleepReq,
    input wire logic subReq,
    input wire logic mainReq,
    input wire logic stopReq,
    input wire logic stop2Sel,
    input wire logic systemClockModeMainOff,
    input wire logic anyIrq,
    // Wake sources
    // Levels; the timer counts only when event-clocked
    input wire logic extIrq,
    input wire logic watchIrq,
    input wire logic timerIrq,
    input wire logic eventCounterInputPin,
    input wire logic extEn,
    input wire logic watchEn,
    input wire logic timerEn,
    // Clock enables
    // Decoded from the registered mode and phase; main osc also from the live mode bit
    output logic mainOscEn,
    output logic subOscEn,
    output logic sysClkEn,
    output logic periClkEn,
    output logic watchLcdClkEn,
    output logic mainOscInGround,
    // Reset outputs
    // Registered state and constants for the core, plus the control reset taken live from a source
    output logic coreReset,
    output logic ctrlRegReset,
    output logic cpuRun,
    output logic [15:0] vectorAddr,
    output logic [7:0] ramPageReg,
    output logic gFlag,
    output logic [2:0] modeOut,
    output logic sharedResetPortPin
);
    // ==========================================================
    // State
    // One counter serves both waits; only one can run at a time
    typedef struct packed {
        pdr_pkg::pdr_mode_e mode;
        pdr_pkg::pdr_phase_e phase;
        logic [pdr_pkg::CNT_W-1:0] cnt;
        logic [7:0] page;
        logic g;
        logic portVal;
    } pdr_top_s;
    // Next state built in one place, registered in one place
    pdr_top_s st_r, st_nxt;

    // Qualified pin reset, wake request and gated external wake
    logic pinReset;
    logic wake;
    logic extWake;
    // Pin role and merged internal reset
    logic pinIsReset;
    logic anyReset;

    // Limitation: option levels are read live, not latched at power-up
    // Pin is a port only when both options set
    assign pinIsReset = !(porOption && resetPinAsPortOption);

    // ==========================================================
    // Submodules
    // Low-time filter on the reset pin; idle while the pin is a port
    pdr_pin_filter uFilter (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .pinLowN(resetPinN),
        .pinIsReset(pinIsReset),
        .pinReset(pinReset)
    );

    // Only enabled interrupts may end stop
    pdr_wake_gate uWake (
        .extIrq(extIrq),
        .watchIrq(watchIrq),
        .timerIrq(timerIrq),
        .eventCounterInputPin(eventCounterInputPin),
        .extEn(extEn),
        .watchEn(watchEn),
        .timerEn(timerEn),
        .wake(wake),
        .extWake(extWake)
    );

    // Power-on reset also covers the supply ramp
    // Four sources merged into one internal reset
    assign anyReset = pinReset | porReset | brownoutReset | watchdogReset;

    // Down-counter load value helper
    // Loaded with N-1: zero is held one more edge, N in all
    function automatic logic [pdr_pkg::CNT_W-1:0] waitLoad(input int cyc);
        waitLoad = pdr_pkg::CNT_W'(cyc - 1);
    endfunction : waitLoad

    // Counter end test, shared by both waits
    function automatic logic cntDone(input logic [pdr_pkg::CNT_W-1:0] cnt);
        cntDone = (cnt == '0);
    endfunction : cntDone

    // Either stop flavour
    function automatic logic isStop(input pdr_pkg::pdr_mode_e mode);
        isStop = (mode == pdr_pkg::MODE_STOP) || (mode == pdr_pkg::MODE_STOP2);
    endfunction : isStop

    // ==========================================================
    // Sequencer
    always_comb begin
        st_nxt = st_r;
        // Pin level kept for its port role
        st_nxt.portVal = resetPinN;
        // A live source overrides every phase and request
        if (anyReset) begin
            // Control state to defaults; RAM untouched outside
            st_nxt.phase = pdr_pkg::PH_RESET;
            st_nxt.mode = pdr_pkg::MODE_MAIN;
            st_nxt.page = pdr_pkg::RAM_PAGE_RST;
            st_nxt.g = 1'b0;
            st_nxt.cnt = waitLoad(RstWaitCyc);
        end else begin
            case (st_r.phase)
                pdr_pkg::PH_RESET: begin
                    // Hold core until start-up wait ends
                    // A source still live keeps reloading the count above
                    if (cntDone(st_r.cnt)) begin
                        st_nxt.phase = pdr_pkg::PH_RUN;
                    end else begin
                        st_nxt.cnt = st_r.cnt - 1'b1;
                    end
                end
                pdr_pkg::PH_RUN: begin
                    // Priority: stop, sleep, irq wake, sub, main
                    if (stopReq) begin
                        st_nxt.phase = pdr_pkg::PH_STOPPED;
                        // Flavour sampled with the request
                        st_nxt.mode = stop2Sel ? pdr_pkg::MODE_STOP2 : pdr_pkg::MODE_STOP;
                    end else if (sleepReq) begin
                        // Sleep flavour follows current run mode
                        st_nxt.mode = (st_r.mode == pdr_pkg::MODE_SUB) ? pdr_pkg::MODE_SUBSLEEP
                                                                       : pdr_pkg::MODE_SLEEP;
                    // Any interrupt ends either sleep mode
                    end else if ((st_r.mode == pdr_pkg::MODE_SLEEP) && anyIrq) begin
                        st_nxt.mode = pdr_pkg::MODE_MAIN;
                    end else if ((st_r.mode == pdr_pkg::MODE_SUBSLEEP) && anyIrq) begin
                        st_nxt.mode = pdr_pkg::MODE_SUB;
                    end else if (subReq) begin
                        st_nxt.mode = pdr_pkg::MODE_SUB;
                    end else if (mainReq) begin
                        st_nxt.mode = pdr_pkg::MODE_MAIN;
                    end
                end
                pdr_pkg::PH_STOPPED: begin
                    // Only gated wake sources end stop
                    // Mode stays stop so the clocks stay off until then
                    if (wake) begin
                        st_nxt.phase = pdr_pkg::PH_WAKEWAIT;
                        st_nxt.cnt = waitLoad(StopWaitCyc);
                    end
                end
                pdr_pkg::PH_WAKEWAIT: begin
                    // Core and peripheral clocks stay off during start-up; the count runs, and the sub clock unless stop 2
                    if (cntDone(st_r.cnt)) begin
                        st_nxt.phase = pdr_pkg::PH_RUN;
                        // Wake always lands in main mode; registers kept
                        st_nxt.mode = pdr_pkg::MODE_MAIN;
                    end else begin
                        st_nxt.cnt = st_r.cnt - 1'b1;
                    end
                end
                default: begin
                    // Unreachable code: fall back to the reset phase
                    st_nxt.phase = pdr_pkg::PH_RESET;
                end
            endcase
        end
    end

    // Reset loads the full reset wait directly
    // Same count as a source reset, so both paths wait alike
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r.mode <= pdr_pkg::MODE_MAIN;
            st_r.phase <= pdr_pkg::PH_RESET;
            st_r.cnt <= pdr_pkg::CNT_W'(RstWaitCyc - 1);
            st_r.page <= pdr_pkg::RAM_PAGE_RST;
            st_r.g <= 1'b0;
            st_r.portVal <= 1'b1;
        end else if (ce) begin
            // ce low holds the whole state, counters too
            st_r <= st_nxt;
        end
    end

    // ==========================================================
    // Clock gating by mode
    always_comb begin
        // Defaults: both oscillators and peripherals on, core off
        mainOscEn = 1'b1;
        subOscEn = 1'b1;
        sysClkEn = 1'b0;
        periClkEn = 1'b1;
        case (st_r.mode)
            // Everything runs
            pdr_pkg::MODE_MAIN: begin
                sysClkEn = 1'b1;
            end
            // Core stops, peripherals keep running
            pdr_pkg::MODE_SLEEP: begin
                sysClkEn = 1'b0;
            end
            // Main oscillator follows the mode register bit
            pdr_pkg::MODE_SUB: begin
                mainOscEn = !systemClockModeMainOff;
                sysClkEn = 1'b1;
            end
            // Core stops on the sub clock
            pdr_pkg::MODE_SUBSLEEP: begin
                mainOscEn = !systemClockModeMainOff;
            end
            // Only the sub clock domain survives
            pdr_pkg::MODE_STOP: begin
                mainOscEn = 1'b0;
                periClkEn = 1'b0;
            end
            // Sub clock stops as well
            pdr_pkg::MODE_STOP2: begin
                mainOscEn = 1'b0;
                subOscEn = 1'b0;
                periClkEn = 1'b0;
            end
            // Unused codes keep the core off
            default: begin
                sysClkEn = 1'b0;
            end
        endcase
        // Wake wait keeps core and peripheral clocks off; the reset phase leaves them to the mode
        // Oscillators keep the stop setting until the count ends
        if (st_r.phase == pdr_pkg::PH_WAKEWAIT) begin
            sysClkEn = 1'b0;
            periClkEn = 1'b0;
        end
    end

    // Watch timer and display run on sub clock in stop
    assign watchLcdClkEn = subOscEn;
    // Limitation: they follow the sub oscillator, so stop 2 halts them
    // Oscillator input grounded while main osc is stopped for stop
    assign mainOscInGround = isStop(st_r.mode);

    // ==========================================================
    // Reset outputs
    // Core held for the whole reset phase
    assign coreReset = (st_r.phase == pdr_pkg::PH_RESET);
    // Control registers cleared at once by a live source
    assign ctrlRegReset = anyReset || (st_r.phase == pdr_pkg::PH_RESET);
    // Fetch only when running with the core clock on
    assign cpuRun = (st_r.phase == pdr_pkg::PH_RUN) && sysClkEn;
    // Start address fetched from the top of memory
    assign vectorAddr = pdr_pkg::RESET_VECTOR_ADDR;
    // Page register and G flag as left by reset
    assign ramPageReg = st_r.page;
    assign gFlag = st_r.g;
    // Current mode, for the clock tree and status
    assign modeOut = st_r.mode;
    // Port value only when the pin is repurposed
    assign sharedResetPortPin = pinIsReset ? 1'b1 : st_r.portVal;
endmodule : power_down_and_reset_control

// ---- dv/pdr_asserts.sv ----
// Purpose: port checks for the power-down and reset controller
// Assumes: ce stays high while a reset wait runs
// Notes: bound to every instance at the file foot
`timescale 1ns/1ps
module pdr_checker #(
    parameter int RstWaitCyc = 20
) (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Reset sources and options
    input wire logic resetPinN,
    input wire logic porReset,
    input wire logic brownoutReset,
    input wire logic watchdogReset,
    input wire logic porOption,
    input wire logic resetPinAsPortOption,
    input wire logic systemClockModeMainOff,
    // Design outputs
    input wire logic mainOscEn,
    input wire logic subOscEn,
    input wire logic sysClkEn,
    input wire logic periClkEn,
    input wire logic watchLcdClkEn,
    input wire logic mainOscInGround,
    input wire logic coreReset,
    input wire logic ctrlRegReset,
    input wire logic cpuRun,
    input wire logic [15:0] vectorAddr,
    input wire logic [2:0] modeOut,
    input wire logic sharedResetPortPin
);
    // ==========================================
    // Helper: clean cycles spent in core reset
    int heldCnt_r;
    logic anySrc;
    assign anySrc = porReset | brownoutReset | watchdogReset | ~resetPinN;
    // Restarts on any live source, so a late source never reads as a short wait
    always_ff @(posedge clk or posedge rst) begin
        if (rst) heldCnt_r <= 0;
        else if (!coreReset || anySrc) heldCnt_r <= 0;
        else if (ce) heldCnt_r <= heldCnt_r + 1;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // ==========================================
    // Mode clock gating
    a_sub_main_osc: assert property (modeOut inside {3'h2, 3'h3} |-> mainOscEn == !systemClockModeMainOff)
        else $error("main oscillator wrong in sub mode");
    a_stop_peri_off: assert property (modeOut == 3'h4 |-> !periClkEn && watchLcdClkEn && subOscEn)
        else $error("stop peripheral clocks wrong");
    a_sys_clk_modes: assert property (!coreReset |-> sysClkEn == (modeOut inside {3'h0, 3'h2}))
        else $error("system clock not tied to mode");
    a_stop2_all_off: assert property (modeOut == 3'h5 |-> !subOscEn && !mainOscEn && !sysClkEn)
        else $error("clock alive in stop 2");
    a_stop_ground: assert property (modeOut inside {3'h4, 3'h5} |-> mainOscInGround && !mainOscEn)
        else $error("main input not grounded in stop");
    a_stop_no_run: assert property (modeOut inside {3'h4, 3'h5} |-> !cpuRun)
        else $error("cpu runs during stop or start-up");
    // ==========================================
    // Reset merge, pin qualification, release
    a_src_merge: assert property ((porReset || brownoutReset || watchdogReset) |-> ctrlRegReset)
        else $error("reset source not merged");
    a_src_to_core: assert property (ce && (porReset || brownoutReset || watchdogReset) |=> coreReset)
        else $error("core reset late after source");
    a_pin_short: assert property ($fell(resetPinN) && !ctrlRegReset |=> (!coreReset) [*7])
        else $error("pin reset taken too early");
    a_pin_long: assert property ((!resetPinN && ce && !(porOption && resetPinAsPortOption)) [*8]
        ##1 (!resetPinN && ce) |-> ##[0:3] coreReset)
        else $error("long pin low gave no reset");
    a_wait_release: assert property ($fell(coreReset) |-> heldCnt_r >= RstWaitCyc - 1 && heldCnt_r <= RstWaitCyc + 1)
        else $error("reset release wait wrong");
    a_reset_state: assert property (coreReset |-> modeOut == 3'h0 && vectorAddr == 16'hFFFE)
        else $error("reset state wrong");
    a_port_pin_idle: assert property (!(porOption && resetPinAsPortOption) |-> sharedResetPortPin)
        else $error("port pin active while pin is reset");
endmodule : pdr_checker

bind power_down_and_reset_control pdr_checker #(.RstWaitCyc(RstWaitCyc)) u_chk (
    .clk(clk), .rst(rst), .ce(ce), .resetPinN(resetPinN), .porReset(porReset),
    .brownoutReset(brownoutReset), .watchdogReset(watchdogReset), .porOption(porOption),
    .resetPinAsPortOption(resetPinAsPortOption), .systemClockModeMainOff(systemClockModeMainOff),
    .mainOscEn(mainOscEn), .subOscEn(subOscEn), .sysClkEn(sysClkEn), .periClkEn(periClkEn),
    .watchLcdClkEn(watchLcdClkEn), .mainOscInGround(mainOscInGround), .coreReset(coreReset),
    .ctrlRegReset(ctrlRegReset), .cpuRun(cpuRun), .vectorAddr(vectorAddr), .modeOut(modeOut),
    .sharedResetPortPin(sharedResetPortPin));

// ---- dv/pdr_far_side.sv ----
// Purpose: external reset circuit and wake sources
// Assumes: driven on rising clk edges
// Notes: tasks are called by the bench
`timescale 1ns/1ps
module pdr_far_side (
    // Clock
    input wire logic clk,
    // Reset circuit
    output logic resetPinN = 1'b1,
    output logic porReset = 1'b1,
    output logic brownoutReset = 1'b0,
    output logic watchdogReset = 1'b0,
    // Wake sources
    output logic extIrq = 1'b0,
    output logic watchIrq = 1'b0,
    output logic timerIrq = 1'b0
);
    // Supply ramp: power-on reset held a few cycles
    initial begin
        repeat (3) @(posedge clk);
        porReset <= 1'b0;
    end
    // Pin low for n cycles; short holds act as glitches
    task automatic pin_low(input int n);
        @(posedge clk);
        resetPinN <= 1'b0;
        repeat (n) @(posedge clk);
        resetPinN <= 1'b1;
    endtask : pin_low
    // Pulse one source: 0 power-on, 1 brown-out, 2 watchdog
    task automatic src_pulse(input int k);
        @(posedge clk);
        case (k)
            0: porReset <= 1'b1;
            1: brownoutReset <= 1'b1;
            default: watchdogReset <= 1'b1;
        endcase
        repeat (3) @(posedge clk);
        {porReset, brownoutReset, watchdogReset} <= 3'h0;
    endtask : src_pulse
    // Wake level: 0 external, 1 watch, 2 timer
    task automatic irq(input int k, input logic v);
        @(posedge clk);
        case (k)
            0: extIrq <= v;
            1: watchIrq <= v;
            default: timerIrq <= v;
        endcase
    endtask : irq
endmodule : pdr_far_side

// ---- dv/tb_power_down_and_reset_control.sv ----
// Purpose: self-checking bench for the power-down and reset controller
// Assumes: shortened reset and start-up waits
// Notes: seeded random mode bit and stop flavour
`timescale 1ns/1ps
module tb_power_down_and_reset_control;
    localparam int RstW = 20;
    localparam int StopW = 10;
    logic clk = 1'b0, rst = 1'b1, ce = 1'b1, porOption = 1'b0, resetPinAsPortOption = 1'b0;
    logic sleepReq = 1'b0, subReq = 1'b0, mainReq = 1'b0, stopReq = 1'b0, stop2Sel = 1'b0;
    logic systemClockModeMainOff = 1'b0, anyIrq = 1'b0, eventCounterInputPin = 1'b0;
    logic extEn = 1'b0, watchEn = 1'b0, timerEn = 1'b0;
    logic resetPinN, porReset, brownoutReset, watchdogReset, extIrq, watchIrq, timerIrq;
    logic mainOscEn, subOscEn, sysClkEn, periClkEn, watchLcdClkEn, mainOscInGround;
    logic coreReset, ctrlRegReset, cpuRun, gFlag, sharedResetPortPin;
    logic [15:0] vectorAddr;
    logic [7:0] ramPageReg;
    logic [2:0] modeOut;
    int failures = 0, samplesChecked = 0, cycles = 0;
    power_down_and_reset_control #(.RstWaitCyc(RstW), .StopWaitCyc(StopW)) i_dut (.*);
    pdr_far_side u_env (.*);
    always #5 clk = ~clk;
    task automatic final_report();
        $display("checks %0d mismatches %0d", samplesChecked, failures);
        if (failures == 0 && samplesChecked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : final_report
    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            failures++;
            final_report();
        end
    end
    task automatic chk(input logic ok, input string what);
        samplesChecked++;
        if (ok !== 1'b1) begin
            failures++;
            $display("BAD t=%0t %s", $time, what);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic waitRun(input int lim, output int n);
        n = 0;
        while (cpuRun !== 1'b1 && n < lim) begin
            tick(1);
            n++;
        end
    endtask : waitRun
    // Request pulse: 0 sleep, 1 sub, 2 main, 3 stop, 4 irq
    task automatic req(input int k);
        @(posedge clk);
        case (k)
            0: sleepReq <= 1'b1;
            1: subReq <= 1'b1;
            2: mainReq <= 1'b1;
            3: stopReq <= 1'b1;
            default: anyIrq <= 1'b1;
        endcase
        @(posedge clk);
        {sleepReq, subReq, mainReq, stopReq, anyIrq} <= 5'h00;
        #1;
    endtask : req
    // Expected {main osc, sub osc, system, peripheral} per mode
    function automatic logic [3:0] expClk(input logic [2:0] m, input logic off);
        case (m)
            3'h0: expClk = 4'hF;
            3'h1: expClk = 4'hD;
            3'h2: expClk = {!off, 3'h7};
            3'h3: expClk = {!off, 3'h5};
            3'h4: expClk = 4'h4;
            default: expClk = 4'h0;
        endcase
    endfunction : expClk
    task automatic modeStep(input int r, input logic [2:0] m);
        req(r);
        chk(modeOut === m && {mainOscEn, subOscEn, sysClkEn, periClkEn} === expClk(m, systemClockModeMainOff), "mode");
    endtask : modeStep
    initial begin
        int n;
        int k;
        void'($urandom(32'hF879));
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        waitRun(200, n);
        chk(n >= RstW - 2 && n <= RstW + 2, "release wait");
        chk(modeOut === 3'h0 && ramPageReg === 8'h00 && gFlag === 1'b0 && vectorAddr === 16'hFFFE, "init");
        $display("test reset done");
        for (k = 0; k < 3; k++) begin
            @(posedge clk);
            systemClockModeMainOff <= 1'($urandom);
            modeStep(1, 3'h2);
            modeStep(0, 3'h3);
            modeStep(4, 3'h2);
            modeStep(2, 3'h0);
            modeStep(0, 3'h1);
            modeStep(4, 3'h0);
        end
        $display("test modes done");
        for (k = 0; k < 9; k++) begin
            // PLL off and not selected, long start-up wait, no-ops after stop
            @(posedge clk);
            stop2Sel <= (k % 3 == 0) ? 1'($urandom) : 1'b0;
            {extEn, watchEn, timerEn} <= {2'h0, k % 3 == 2};
            eventCounterInputPin <= 1'b0;
            req(3);
            chk(modeOut === {2'h2, stop2Sel} && mainOscInGround === 1'b1, "stop entry");
            u_env.irq(k % 3, 1'b1);
            tick(3 * StopW);
            chk(cpuRun === 1'b0 && modeOut[2] === 1'b1, "wake taken while disabled");
            @(posedge clk);
            {extEn, watchEn, timerEn} <= 3'h4 >> (k % 3);
            eventCounterInputPin <= 1'b1;
            waitRun(StopW + 10, n);
            chk(cpuRun === 1'b1 && n >= StopW - 1 && modeOut === 3'h0, "wake from stop");
            u_env.irq(k % 3, 1'b0);
        end
        $display("test stop done");
        for (k = 0; k < 3; k++) begin
            req(3);
            u_env.src_pulse(k);
            #1;
            chk(coreReset === 1'b1 && ctrlRegReset === 1'b1, "source reset");
            waitRun(RstW + 20, n);
            chk(n >= RstW - 2 && n <= RstW + 2 && modeOut === 3'h0, "source release");
        end
        $display("test source done");
        @(posedge clk);
        porOption <= 1'b1;
        u_env.pin_low(5);
        tick(4);
        chk(coreReset === 1'b0, "short pin low");
        u_env.pin_low(12);
        #1;
        chk(coreReset === 1'b1, "pin reset");
        waitRun(RstW + 20, n);
        chk(n >= RstW - 2 && n <= RstW + 2, "pin release");
        @(posedge clk);
        resetPinAsPortOption <= 1'b1;
        fork
            u_env.pin_low(12);
        join_none
        tick(8);
        chk(sharedResetPortPin === 1'b0 && coreReset === 1'b0, "pin as port");
        tick(8);
        chk(sharedResetPortPin === 1'b1 && coreReset === 1'b0, "port pin high");
        $display("test pin done");
        final_report();
    end
endmodule : tb_power_down_and_reset_control
